// *** rtl/hop_table_and_status_regs.sv ***
// hop frequency table, hop pointer and status registers of the transceiver
// assumes one 250 MHz clock; all inputs synchronous except hop_strobe
`timescale 1ns/1ps
`include "hop_regs_cfg.svh"
module hop_table_and_status_regs #(
  parameter int SWITCH_CYC = `SWITCH_CYCLES
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst_n,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic                   reg_status,
  input  wire logic [5:0]             reg_addr,
  input  wire hop_regs_pkg::byte_type reg_wdata,
  output      hop_regs_pkg::byte_type reg_rdata,
  input  wire logic                   hop_strobe,
  input  wire logic                   supply_fault,
  input  wire logic                   ch1_synth_lock,
  input  wire logic                   ch2_synth_lock,
  input  wire logic [7:0]             ch1_rssi,
  input  wire logic [7:0]             ch2_rssi,
  input  wire logic [6:0]             ch1_gain_control,
  input  wire logic [6:0]             ch2_gain_control,
  input  wire logic                   ch1_tx_active,
  input  wire logic                   ch2_tx_active,
  input  wire logic [11:0]            ch1_tx_power,
  input  wire logic [11:0]            ch2_tx_power,
  input  wire logic                   ext_ref_in,
  output      hop_regs_pkg::freq_type ch1_synth_freq,
  output      hop_regs_pkg::freq_type ch2_synth_freq,
  output logic                        ch1_synth_load,
  output logic                        ch2_synth_load,
  output logic [6:0]                  ch1_rx_gain,
  output logic [6:0]                  ch2_rx_gain,
  output logic                        ch1_power_down,
  output logic                        ch2_power_down,
  output logic [3:0]                  analog_probe_point,
  output logic                        ext_ref_select,
  output logic [2:0]                  hop_pointer,
  output logic                        switch_busy,
  output logic                        switch_late
);
  import hop_regs_pkg::*;

  localparam int SW_W = $clog2(SWITCH_CYC + 1);
  localparam int RF_W = $clog2(`REF_CYCLES + 1);
  localparam logic [SW_W-1:0] SW_LIMIT = SW_W'(SWITCH_CYC);
  localparam logic [RF_W-1:0] RF_LIMIT = RF_W'(`REF_CYCLES);
  // -----------------------------
  // helpers
  // -----------------------------
  byte_type         ctrl_q [`CTRL_COUNT];
  logic [1:0]       lock_w;
  logic [7:0]       rssi_w [2];
  logic [6:0]       gctl_w [2];
  logic [1:0]       txa_w;
  logic [11:0]      txp_w [2];
  assign lock_w = {ch2_synth_lock, ch1_synth_lock};
  assign rssi_w = '{ch1_rssi, ch2_rssi};
  assign gctl_w = '{ch1_gain_control, ch2_gain_control};
  assign txa_w  = {ch2_tx_active, ch1_tx_active};
  assign txp_w  = '{ch1_tx_power, ch2_tx_power};
  // entry assembled from four bytes, lowest address is the low byte
  function automatic freq_type entry(input logic [2:0] idx);
    logic [5:0] b;
    b = 6'(`FREQ_BASE_ADDR + {1'b0, idx, 2'b00});
    entry = {ctrl_q[b + 6'h03], ctrl_q[b + 6'h02],
             ctrl_q[b + 6'h01], ctrl_q[b]};
  endfunction
  function automatic logic [5:0] ch_addr(input int c, input logic [5:0] ofs);
    ch_addr = 6'(`CH1_INDEX_ADDR + 6'(c) * `CH_STRIDE + ofs);
  endfunction
  // out-of-range lengths are clamped so the pointer always stays legal
  logic [3:0] hop_len_w;
  assign hop_len_w = (ctrl_q[`HOP_LENGTH_ADDR] < `HOP_LEN_MIN) ? 4'(`HOP_LEN_MIN) :
                     (ctrl_q[`HOP_LENGTH_ADDR] > `HOP_LEN_MAX) ? 4'(`HOP_LEN_MAX) :
                     4'(ctrl_q[`HOP_LENGTH_ADDR]);
  logic wr_ctrl_w;
  assign wr_ctrl_w = reg_wr && !reg_status;
  // -----------------------------
  // control register file
  // -----------------------------
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `CTRL_COUNT; i++)
        ctrl_q[i] <= `CTRL_RESET;
    end
    else if (wr_ctrl_w && (reg_addr < 6'(`CTRL_COUNT)))
    begin
      ctrl_q[reg_addr] <= reg_wdata;
    end
  end
  // -----------------------------
  // hop strobe capture
  // -----------------------------
  logic       strobe_s1_q;
  logic       strobe_s2_q;
  logic       strobe_s3_q;
  logic       hop_edge_w;
  logic [2:0] ptr_q;
  logic [2:0] ptr_d;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strobe_s1_q <= 1'b0;
      strobe_s2_q <= 1'b0;
      strobe_s3_q <= 1'b0;
    end
    else
    begin
      strobe_s1_q <= hop_strobe;
      strobe_s2_q <= strobe_s1_q;
      strobe_s3_q <= strobe_s2_q;
    end
  end
  // a held level produces only one hop
  assign hop_edge_w = strobe_s2_q && !strobe_s3_q;
  assign ptr_d = ({1'b0, ptr_q} + 4'h1 >= hop_len_w) ? 3'h0 : 3'(ptr_q + 3'h1);
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ptr_q <= 3'h0;
    else if (hop_edge_w)
      ptr_q <= ptr_d;
    else if ({1'b0, ptr_q} >= hop_len_w)
      ptr_q <= 3'h0;
  end

  assign hop_pointer = ptr_q;
  // -----------------------------
  // per-channel synthesizer and gain
  // -----------------------------
  freq_type   freq_q [2];
  logic [1:0] load_q;
  logic [6:0] gain_q [2];
  logic [1:0] pdn_q;
  logic [11:0] txp_q [2];
  for (genvar c = 0; c < 2; c++)
  begin : g_ch
    logic idx_wr_w;
    assign idx_wr_w = wr_ctrl_w && (reg_addr == ch_addr(c, 6'h00));
    // a hop wins over an index write landing in the same cycle
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        freq_q[c] <= '0;
        load_q[c] <= 1'b0;
      end
      else if (hop_edge_w)
      begin
        freq_q[c] <= entry(ptr_d);
        load_q[c] <= 1'b1;
      end
      else if (idx_wr_w)
      begin
        freq_q[c] <= entry(reg_wdata[`INDEX_MSB:0]);
        load_q[c] <= 1'b1;
      end
      else
        load_q[c] <= 1'b0;
    end
    // in external AGC mode the block only applies gain; the decision stays with the partner
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
      begin
        gain_q[c] <= '0;
        pdn_q[c]  <= 1'b0;
      end
      else
      begin
        if (ctrl_q[ch_addr(c, `CH_MODE_OFS)][`AGC_MODE_MSB:0] == `AGC_EXTERNAL)
          gain_q[c] <= gctl_w[c];
        else
          gain_q[c] <= ctrl_q[ch_addr(c, `CH_GAIN_OFS)][`GAIN_MSB:0];
        pdn_q[c] <= ctrl_q[ch_addr(c, 6'h00)][`POWER_DOWN_BIT];
      end
    end
    // detector output is meaningless while receiving, so hold the last burst
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
      if (!rst_n)
        txp_q[c] <= '0;
      else if (txa_w[c])
        txp_q[c] <= txp_w[c];
    end
  end
  assign ch1_synth_freq = freq_q[0];
  assign ch2_synth_freq = freq_q[1];
  assign ch1_synth_load = load_q[0];
  assign ch2_synth_load = load_q[1];
  assign ch1_rx_gain    = gain_q[0];
  assign ch2_rx_gain    = gain_q[1];
  assign ch1_power_down = pdn_q[0];
  assign ch2_power_down = pdn_q[1];
  // -----------------------------
  // switch time supervision
  // -----------------------------
  switch_state_type sw_state_q;
  logic [SW_W-1:0]  sw_cnt_q;
  logic             late_q;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sw_state_q <= SW_IDLE;
      sw_cnt_q   <= '0;
      late_q     <= 1'b0;
    end
    else if (|load_q)
    begin
      sw_state_q <= SW_SETTLE;
      sw_cnt_q   <= '0;
      late_q     <= 1'b0;
    end
    else
    begin
      case (sw_state_q)
        SW_IDLE:
          sw_cnt_q <= '0;
        SW_SETTLE:
        begin
          // lock seen or deadline reached ends the switch either way
          if (&lock_w)
            sw_state_q <= SW_IDLE;
          else if (sw_cnt_q == SW_LIMIT - SW_W'(1))
          begin
            sw_state_q <= SW_IDLE;
            late_q     <= 1'b1;
          end
          else
            sw_cnt_q <= sw_cnt_q + SW_W'(1);
        end
        default:
          sw_state_q <= SW_IDLE;
      endcase
    end
  end

  logic busy_q;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      busy_q <= 1'b0;
    else
      busy_q <= (|load_q) || (sw_state_q == SW_SETTLE && !(&lock_w)
                && sw_cnt_q != SW_LIMIT - SW_W'(1));
  end
  assign switch_busy = busy_q;
  assign switch_late = late_q;
  // -----------------------------
  // reference and probe select
  // -----------------------------
  logic            ref_prev_q;
  logic [RF_W-1:0] ref_cnt_q;
  logic            ref_sel_q;
  logic [3:0]      probe_q;

  // any transition within the window means the reference is present
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ref_prev_q <= 1'b0;
      ref_cnt_q  <= '0;
      ref_sel_q  <= 1'b0;
    end
    else
    begin
      ref_prev_q <= ext_ref_in;
      if (ext_ref_in != ref_prev_q)
      begin
        ref_cnt_q <= RF_LIMIT;
        ref_sel_q <= 1'b1;
      end
      else if (ref_cnt_q != '0)
        ref_cnt_q <= ref_cnt_q - RF_W'(1);
      else
        ref_sel_q <= 1'b0;
    end
  end
  assign ext_ref_select = ref_sel_q;

  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      probe_q <= 4'h0;
    else if (ctrl_q[`PROBE_SELECT_ADDR][`PROBE_MSB:0] > `PROBE_LAST)
      probe_q <= 4'h0;
    else
      probe_q <= ctrl_q[`PROBE_SELECT_ADDR][`PROBE_MSB:0];
  end
  assign analog_probe_point = probe_q;
  // -----------------------------
  // read path
  // -----------------------------
  byte_type rdata_q;
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      rdata_q <= 8'h00;
    else if (reg_rd && !reg_status)
      rdata_q <= (reg_addr < 6'(`CTRL_COUNT)) ? ctrl_q[reg_addr] : 8'h00;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ST_FAULT_ADDR:        rdata_q <= {7'h00, supply_fault};
        `ST_LOCK_ADDR:         rdata_q <= {6'h00, lock_w};
        `ST_RSSI_ADDR:         rdata_q <= rssi_w[0];
        `ST_RSSI_ADDR + 6'h01: rdata_q <= rssi_w[1];
        `ST_GAIN_ADDR:         rdata_q <= {1'b0, gain_q[0]};
        `ST_GAIN_ADDR + 6'h01: rdata_q <= {1'b0, gain_q[1]};
        `ST_TXP_ADDR:          rdata_q <= txp_q[0][7:0];
        `ST_TXP_ADDR + 6'h01:  rdata_q <= {4'h0, txp_q[0][11:8]};
        `ST_TXP_ADDR + 6'h02:  rdata_q <= txp_q[1][7:0];
        `ST_TXP_ADDR + 6'h03:  rdata_q <= {4'h0, txp_q[1][11:8]};
        default:               rdata_q <= 8'h00;
      endcase
    end
  end
  assign reg_rdata = rdata_q;
  // -----------------------------
  // assertions
  // -----------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_wrap;
    hop_edge_w && ({1'b0, ptr_q} + 4'h1 >= hop_len_w) |=> ptr_q == 3'h0;
  endproperty
  a_wrap: assert property (p_wrap) else $error("pointer did not wrap");
  property p_step;
    hop_edge_w && ({1'b0, ptr_q} + 4'h1 < hop_len_w) |=> ptr_q == $past(ptr_q) + 3'h1;
  endproperty
  a_step: assert property (p_step) else $error("pointer did not step");
  property p_range;
    $stable(hop_len_w) && $stable(ptr_q) && !$past(hop_edge_w) |-> {1'b0, ptr_q} < hop_len_w;
  endproperty
  a_range: assert property (p_range) else $error("pointer beyond list");
  // the synchroniser adds two or three cycles; the held level is then ignored
  property p_edge;
    $rose(hop_strobe) |-> ##[2:3] hop_edge_w ##1 !hop_edge_w [*4];
  endproperty
  a_edge: assert property (p_edge) else $error("strobe edge mishandled");
  property p_late;
    sw_state_q == SW_SETTLE && !(&lock_w) && !(|load_q) && sw_cnt_q == SW_LIMIT - SW_W'(1)
      |=> switch_late && !switch_busy;
  endproperty
  a_late: assert property (p_late) else $error("deadline not flagged");
  property p_reindex;
    wr_ctrl_w && reg_addr == `CH1_INDEX_ADDR && !hop_edge_w
      |=> ch1_synth_load && ch1_synth_freq == entry($past(reg_wdata[`INDEX_MSB:0]));
  endproperty
  a_reindex: assert property (p_reindex) else $error("index write lost");
  property p_fault;
    reg_rd && reg_status && reg_addr == `ST_FAULT_ADDR |=> reg_rdata[0] == $past(supply_fault);
  endproperty
  a_fault: assert property (p_fault) else $error("fault bit wrong");
  property p_lock;
    reg_rd && reg_status && reg_addr == `ST_LOCK_ADDR
      |=> reg_rdata[1:0] == $past({ch2_synth_lock, ch1_synth_lock});
  endproperty
  a_lock: assert property (p_lock) else $error("lock bits wrong");
  property p_ref;
    ext_ref_in != ref_prev_q |=> ext_ref_select;
  endproperty
  a_ref: assert property (p_ref) else $error("reference not taken");
  property p_gain;
    ctrl_q[`CH1_INDEX_ADDR + `CH_MODE_OFS][`AGC_MODE_MSB:0] == `AGC_EXTERNAL
      |=> ch1_rx_gain == $past(ch1_gain_control);
  endproperty
  a_gain: assert property (p_gain) else $error("gain not applied");
  c_hop: cover property (hop_edge_w ##1 ch1_synth_load);
  c_wrap: cover property (hop_edge_w && ptr_d == 3'h0 && ptr_q != 3'h0);
  c_late: cover property ($rose(switch_late));
  c_ref: cover property ($fell(ext_ref_select));
endmodule

// *** rtl/hop_regs_cfg.svh ***
// named offsets, field positions, reset values and timing figures
// assumes the includer works at the system clock rate given here
`ifndef HOP_REGS_CFG_SVH
`define HOP_REGS_CFG_SVH
// -----------------------------
// control register indices
// -----------------------------
`define CH1_INDEX_ADDR    6'h00
`define CH_STRIDE         6'h03
`define CH_MODE_OFS       6'h01
`define CH_GAIN_OFS       6'h02
`define PROBE_SELECT_ADDR 6'h06
`define FREQ_BASE_ADDR    6'h08
`define HOP_LENGTH_ADDR   6'h28
`define CTRL_COUNT        41
`define CTRL_RESET        8'h00
// -----------------------------
// status register indices
// -----------------------------
`define ST_FAULT_ADDR     6'h00
`define ST_LOCK_ADDR      6'h01
`define ST_RSSI_ADDR      6'h02
`define ST_GAIN_ADDR      6'h04
`define ST_TXP_ADDR       6'h06
// -----------------------------
// field positions and values
// -----------------------------
`define INDEX_MSB         2
`define POWER_DOWN_BIT    7
`define AGC_MODE_MSB      1
`define AGC_EXTERNAL      2'h2
`define GAIN_MSB          6
`define PROBE_MSB         3
`define PROBE_LAST        4'h8
`define HOP_LEN_MIN       8'h01
`define HOP_LEN_MAX       8'h08
// -----------------------------
// timing
// -----------------------------
`define CLK_PERIOD_PS     4000
`define SWITCH_TIME_US    500
`define SWITCH_CYCLES     ((`SWITCH_TIME_US * 1000000) / `CLK_PERIOD_PS)
`define REF_WINDOW_NS     1000
`define REF_CYCLES        ((`REF_WINDOW_NS * 1000) / `CLK_PERIOD_PS)
`endif

// *** rtl/hop_regs_pkg.sv ***
// types shared by the hop table and status block
// assumes the constants header supplies all numeric values
package hop_regs_pkg;
  typedef enum logic [0:0] {SW_IDLE, SW_SETTLE} switch_state_type;
  typedef logic [7:0]  byte_type;
  typedef logic [31:0] freq_type;
endpackage

// *** tb/hop_strobe_source.sv ***
// hop strobe source standing in for the baseband partner
// assumes the bench pulses fire for one clk_sys cycle per strobe
`timescale 1ns/1ps
module hop_strobe_source (
  input  wire logic       clk_sys,
  input  wire logic       fire,
  input  wire logic [7:0] high_cyc,
  output logic            hop_strobe,
  output logic            busy
);
  localparam int LOW_CYC = 6;
  int count = 0;
  initial
  begin
    hop_strobe = 1'h0;
    busy = 1'h0;
  end
  // high_cyc sets a prompt or a slow pulse; the rest gap keeps strobes apart
  always @(posedge clk_sys)
  begin
    if (fire && !busy)
    begin
      hop_strobe <= 1'h1;
      busy <= 1'h1;
      count <= int'(high_cyc) + LOW_CYC;
    end
    else if (count > 0)
    begin
      count <= count - 1;
      if (count == LOW_CYC + 1)
        hop_strobe <= 1'h0;
      if (count == 1)
        busy <= 1'h0;
    end
  end
endmodule

// *** tb/hop_table_and_status_regs_bench.sv ***
// self-checking bench for the hop table and status register block
// assumes the rtl files and the strobe source model are compiled first
`timescale 1ns/1ps
`include "hop_regs_cfg.svh"
module hop_table_and_status_regs_bench;
  import hop_regs_pkg::*;
  localparam int SW_CYC = 50;
  logic        clk_sys, rst_n, reg_wr, reg_rd, reg_status, hop_strobe, fire, src_busy;
  logic        supply_fault, ch1_synth_lock, ch2_synth_lock, ch1_tx_active, ch2_tx_active;
  logic        ext_ref_in, ch1_synth_load, ch2_synth_load, ch1_power_down, ch2_power_down;
  logic        ext_ref_select, switch_busy, switch_late;
  logic [5:0]  reg_addr;
  logic [7:0]  src_high, ch1_rssi, ch2_rssi;
  logic [6:0]  ch1_gain_control, ch2_gain_control, ch1_rx_gain, ch2_rx_gain, gain1, gain2;
  logic [11:0] ch1_tx_power, ch2_tx_power, txp1, txp2;
  logic [3:0]  analog_probe_point;
  logic [2:0]  hop_pointer;
  logic [31:0] m;
  byte_type    reg_wdata, reg_rdata;
  freq_type    ch1_synth_freq, ch2_synth_freq;
  freq_type    entry[8];
  int          n_fail = 0, tests_run = 0, cycles = 0, seed, p = 0;
  int          lens[4] = '{3, 8, 1, 0};
  int          cnt[4] = '{4, 7, 2, 2};

  hop_table_and_status_regs #(.SWITCH_CYC(SW_CYC)) dut (.clk_sys, .rst_n, .reg_wr, .reg_rd,
    .reg_status, .reg_addr, .reg_wdata, .reg_rdata, .hop_strobe, .supply_fault,
    .ch1_synth_lock, .ch2_synth_lock, .ch1_rssi, .ch2_rssi, .ch1_gain_control,
    .ch2_gain_control, .ch1_tx_active, .ch2_tx_active, .ch1_tx_power, .ch2_tx_power,
    .ext_ref_in, .ch1_synth_freq, .ch2_synth_freq, .ch1_synth_load, .ch2_synth_load,
    .ch1_rx_gain, .ch2_rx_gain, .ch1_power_down, .ch2_power_down, .analog_probe_point,
    .ext_ref_select, .hop_pointer, .switch_busy, .switch_late);
  hop_strobe_source partner (.clk_sys, .fire, .high_cyc(src_high), .hop_strobe,
    .busy(src_busy));

  initial
  begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      n_fail++;
      finish_test();
    end
  end

  // ------------------------------
  // tasks and expectations
  // ------------------------------
  task automatic finish_test;
    if (n_fail == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic st, input logic [5:0] a, input byte_type d);
    @(posedge clk_sys);
    reg_wr <= 1'h1;
    reg_status <= st;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'h0;
  endtask

  task automatic rdchk(input logic st, input logic [5:0] a, input byte_type exp);
    @(posedge clk_sys);
    reg_rd <= 1'h1;
    reg_status <= st;
    reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'h0;
    @(posedge clk_sys);
    #1 check(reg_rdata, exp);
  endtask

  function automatic logic [2:0] next_ptr(input int q, input int len);
    int eff;
    eff = (len < 1) ? 1 : (len > 8 ? 8 : len);
    return 3'((q + 1) % eff);
  endfunction

  function automatic byte_type st_exp(input int a);
    case (a)
      0: return {7'h00, supply_fault};
      1: return {6'h00, ch2_synth_lock, ch1_synth_lock};
      2: return ch1_rssi;
      3: return ch2_rssi;
      4: return {1'h0, gain1};
      5: return {1'h0, gain2};
      6: return txp1[7:0];
      7: return {4'h0, txp1[11:8]};
      8: return txp2[7:0];
      9: return {4'h0, txp2[11:8]};
      default: return 8'h00;
    endcase
  endfunction

  // one strobe; the first one runs with locks low so the deadline expires
  task automatic hop(input logic [2:0] exp_p);
    int n;
    int extra;
    n = 0;
    extra = 0;
    @(posedge clk_sys);
    fire <= 1'h1;
    src_high <= 8'(16 + ($random(seed) & 7));
    @(posedge clk_sys);
    fire <= 1'h0;
    while (ch1_synth_load !== 1'h1 && n < 20)
    begin
      @(posedge clk_sys);
      #1 n++;
    end
    check(n <= 3, 1);
    check(hop_pointer, exp_p);
    check(ch2_synth_load, 1);
    check(ch2_synth_freq, entry[exp_p]);
    @(posedge clk_sys);
    #1 check(switch_busy, 1);
    check(ch1_synth_load, 0);
    while (src_busy === 1'h1)
    begin
      @(posedge clk_sys);
      #1 extra += ch1_synth_load;
    end
    check(extra, 0);
    check(switch_busy, !ch1_synth_lock);
    check(switch_late, 0);
    if (ch1_synth_lock === 1'h0)
    begin
      repeat (SW_CYC) @(posedge clk_sys);
      #1 check(switch_late, 1);
      @(posedge clk_sys);
      {ch1_synth_lock, ch2_synth_lock} <= 2'h3;
    end
  endtask

  // ------------------------------
  // main sequence
  // ------------------------------
  initial
  begin
    seed = 32'h94F65D0E;
    {reg_wr, reg_rd, reg_status, fire, supply_fault, ch1_synth_lock, ch2_synth_lock} = '0;
    {ch1_tx_active, ch2_tx_active, ext_ref_in, reg_addr, reg_wdata, src_high} = '0;
    {ch1_rssi, ch2_rssi, ch1_gain_control, ch2_gain_control, ch1_tx_power, ch2_tx_power} = '0;
    {txp1, txp2} = '0;
    rst_n = 1'h0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'h1;
    #1 check(hop_pointer, 0);
    for (int k = 0; k < 8; k++)
    begin
      entry[k] = $random(seed);
      for (int b = 0; b < 4; b++)
        wr(0, 6'(`FREQ_BASE_ADDR + 4 * k + b), entry[k][8 * b +: 8]);
    end
    for (int b = 0; b < 4; b++)
      rdchk(0, 6'(`FREQ_BASE_ADDR + 20 + b), entry[5][8 * b +: 8]);
    for (int k = 0; k < 8; k++)
    begin
      wr(0, 6'h00, 8'(k));
      #1 check(ch1_synth_load, 1);
      check(ch1_synth_freq, entry[k]);
      wr(0, 6'h03, 8'(7 - k));
      #1 check(ch2_synth_freq, entry[7 - k]);
      wr(0, 6'h00, 8'(k));
      #1 check(ch1_synth_load, 1);
    end
    foreach (lens[i])
    begin
      wr(0, `HOP_LENGTH_ADDR, 8'(lens[i]));
      repeat (cnt[i])
      begin
        p = next_ptr(p, lens[i]);
        hop(3'(p));
      end
    end
    repeat (4)
    begin
      @(posedge clk_sys);
      {supply_fault, ch1_synth_lock, ch2_synth_lock, ch1_tx_active, ch2_tx_active}
        <= 5'($random(seed));
      {ch1_rssi, ch2_rssi, ch1_tx_power, ch2_tx_power} <= 40'({$random(seed), $random(seed)});
      ch1_gain_control <= 7'($random(seed));
      ch2_gain_control <= 7'($random(seed));
      m = $random(seed);
      wr(0, 6'h01, {6'h00, m[0], 1'h0});
      wr(0, 6'h04, {6'h00, m[1], 1'h0});
      wr(0, 6'h02, {1'h0, m[8:2]});
      wr(0, 6'h05, {1'h0, m[15:9]});
      gain1 = m[0] ? ch1_gain_control : m[8:2];
      gain2 = m[1] ? ch2_gain_control : m[15:9];
      if (ch1_tx_active)
        txp1 = ch1_tx_power;
      if (ch2_tx_active)
        txp2 = ch2_tx_power;
      repeat (2) @(posedge clk_sys);
      #1 check(ch1_rx_gain, gain1);
      check(ch2_rx_gain, gain2);
      for (int a = 0; a < 11; a++)
        rdchk(1, 6'(a), st_exp(a));
    end
    for (int v = 0; v < 16; v++)
    begin
      wr(0, `PROBE_SELECT_ADDR, 8'(v));
      @(posedge clk_sys);
      #1 check(analog_probe_point, v > 8 ? 0 : v);
    end
    wr(1, `PROBE_SELECT_ADDR, 8'h05);
    rdchk(0, `PROBE_SELECT_ADDR, 8'h0F);
    wr(0, 6'h00, 8'h80);
    @(posedge clk_sys);
    #1 check(ch1_power_down, 1);
    check(ch2_power_down, 0);
    repeat (10)
    begin
      repeat (12) @(posedge clk_sys);
      ext_ref_in <= ~ext_ref_in;
    end
    #1 check(ext_ref_select, 1);
    repeat (300) @(posedge clk_sys);
    #1 check(ext_ref_select, 0);
    finish_test();
  end
endmodule
